// ==== src/shr_ref_order.v ====
`timescale 1ns/1ps
`default_nettype none
`include "shr_defines.vh"
module shr_ref_order #(
  parameter NUM_SLOTS = 16,
  parameter IDX_W = 4
) (
  input wire core_clk, // 10 MHz clock
  input wire reset_n, // asynchronous reset, active low
  input wire [7:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte lanes
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [7:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire slice_start, // pulse: a slice header follows
  input wire [`SHR_CW_W-1:0] cw_data, // decoded code number
  input wire cw_valid, // code number offered
  output wire cw_ready, // code number taken when both high
  input wire [NUM_SLOTS-1:0] slot_valid, // buffer slot holds a picture
  input wire [NUM_SLOTS-1:0] slot_long, // buffer slot is long-term
  input wire [NUM_SLOTS*`SHR_PN_W-1:0] slot_num, // picture number or long index
  output reg [NUM_SLOTS*IDX_W-1:0] order_slots, // slot per relative index
  output reg [IDX_W:0] order_len, // entries in order_slots
  output reg order_done, // pulse: order complete
  output wire slice_busy, // header being parsed
  output reg per_mb_ref_select, // macroblocks carry reference choice
  output reg [2:0] picture_kind, // decoded picture kind
  output reg [2:0] picture_layout, // decoded picture layout
  output reg signed [6:0] quantiser_param, // slice quantiser minus offset
  output reg [1:0] ref_buffering_kind // buffering kind code
);
  // ******************************
  // states
  // ******************************
  localparam S_IDLE = 5'd0, S_SYNC = 5'd1, S_TRK = 5'd2, S_TRV = 5'd3, S_KIND = 5'd4;
  localparam S_LAYOUT = 5'd5, S_SIZEF = 5'd6, S_WID = 5'd7, S_HGT = 5'd8, S_FMB = 5'd9;
  localparam S_SQP = 5'd10, S_SPQP = 5'd11, S_MBC = 5'd12, S_PN = 5'd13, S_REF_SELECT_LAYER_FLAG = 5'd14;
  localparam S_OP = 5'd15, S_ARG = 5'd16, S_REF_BUFFERING_KIND = 5'd17, S_BUILD = 5'd18;

  reg [4:0] state_reg;
  reg [31:0] ctrl_reg;
  reg [`SHR_ERR_W-1:0] err_reg;
  reg [`SHR_ERR_W-1:0] err_pulse_reg;
  reg [`SHR_PN_W-1:0] temporal_ref_value;
  reg [`SHR_PN_W-1:0] picture_number;
  reg [`SHR_PN_W-1:0] pred_reg;
  reg [5:0] slice_quantiser;
  reg [5:0] sp_quantiser;
  reg [15:0] width_reg;
  reg [15:0] height_reg;
  reg [15:0] first_mb_reg;
  reg [15:0] mb_count_reg;
  reg [1:0] remap_op_code;
  reg [1:0] remap_cnt_reg;
  reg [NUM_SLOTS-1:0] moved_reg;
  reg [IDX_W:0] build_r_reg;

  wire arith_entropy_coding = ctrl_reg[`SHR_CTRL_ARITH];
  wire [`SHR_PN_W-1:0] max_long_term_index_plus_one = ctrl_reg[`SHR_CTRL_MLT_LSB +: `SHR_PN_W];
  wire cw_take = cw_valid && cw_ready;
  wire kind_switching = picture_kind >= 3'd5;
  wire kind_intra = picture_kind == 3'd2 || picture_kind == 3'd7;
  wire kind_bidir = picture_kind == 3'd3 || picture_kind == 3'd4;
  wire kind_pred = !kind_intra && !kind_bidir;
  wire [1:0] remap_limit = kind_bidir ? `SHR_REMAP_LIMIT_BI : `SHR_REMAP_LIMIT_ONE;

  assign cw_ready = state_reg != S_IDLE && state_reg != S_BUILD;
  assign slice_busy = state_reg != S_IDLE;

  // ******************************
  // default order ranking
  // ******************************
  wire [NUM_SLOTS-1:0] cell_in;
  wire [NUM_SLOTS*(IDX_W+1)-1:0] cell_rank;
  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g = g + 1) begin : g_cell
      shr_rank_cell #(.NUM_SLOTS(NUM_SLOTS), .IDX_W(IDX_W), .SELF(g)) u_cell (
        .slot_valid(slot_valid),
        .slot_long(slot_long),
        .slot_num(slot_num),
        .cur_num(picture_number),
        .lt_limit(max_long_term_index_plus_one),
        .in_order(cell_in[g]),
        .rank(cell_rank[g*(IDX_W+1) +: IDX_W+1])
      );
    end
  endgenerate

  // ******************************
  // searches
  // ******************************
  integer k;
  reg [`SHR_PN_W-1:0] abs_picnum_delta;
  reg [`SHR_PN_W-1:0] target_num;
  reg pn_dup;
  reg hit;
  reg [IDX_W-1:0] hit_idx;
  reg bhit;
  reg [IDX_W-1:0] bidx;
  always @* begin
    abs_picnum_delta = cw_data[`SHR_PN_W-1:0] + 1'b1;
    // ten-bit arithmetic is the modulo wrap
    target_num = (remap_op_code == `SHR_OP_NEG) ? pred_reg - abs_picnum_delta
                                                 : pred_reg + abs_picnum_delta;
    pn_dup = 1'b0;
    hit = 1'b0;
    hit_idx = {IDX_W{1'b0}};
    bhit = 1'b0;
    bidx = {IDX_W{1'b0}};
    for (k = 0; k < NUM_SLOTS; k = k + 1) begin
      if (slot_valid[k] && !slot_long[k] &&
          slot_num[k*`SHR_PN_W +: `SHR_PN_W] == cw_data[`SHR_PN_W-1:0]) begin
        pn_dup = 1'b1;
      end
      if (!hit && slot_valid[k] && (remap_op_code == `SHR_OP_LONG ?
          (slot_long[k] && slot_num[k*`SHR_PN_W +: `SHR_PN_W] == cw_data[`SHR_PN_W-1:0]) :
          (!slot_long[k] && slot_num[k*`SHR_PN_W +: `SHR_PN_W] == target_num))) begin
        hit = 1'b1;
        hit_idx = k[IDX_W-1:0];
      end
      if (cell_in[k] && cell_rank[k*(IDX_W+1) +: IDX_W+1] == build_r_reg) begin
        bhit = 1'b1;
        bidx = k[IDX_W-1:0];
      end
    end
  end

  // ******************************
  // header parser
  // ******************************
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= S_IDLE;
      err_pulse_reg <= {`SHR_ERR_W{1'b0}};
      temporal_ref_value <= {`SHR_PN_W{1'b0}};
      picture_number <= {`SHR_PN_W{1'b0}};
      pred_reg <= {`SHR_PN_W{1'b0}};
      picture_kind <= 3'h0;
      picture_layout <= 3'h0;
      per_mb_ref_select <= 1'b0;
      slice_quantiser <= 6'h00;
      sp_quantiser <= 6'h00;
      quantiser_param <= 7'sh00;
      width_reg <= 16'h0000;
      height_reg <= 16'h0000;
      first_mb_reg <= 16'h0000;
      mb_count_reg <= 16'h0000;
      remap_op_code <= 2'h0;
      remap_cnt_reg <= 2'h0;
      ref_buffering_kind <= 2'h0;
      moved_reg <= {NUM_SLOTS{1'b0}};
      build_r_reg <= {(IDX_W+1){1'b0}};
      order_slots <= {NUM_SLOTS*IDX_W{1'b0}};
      order_len <= {(IDX_W+1){1'b0}};
      order_done <= 1'b0;
    end else begin
      err_pulse_reg <= {`SHR_ERR_W{1'b0}};
      order_done <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (slice_start) begin
            // each slice starts from a clean order
            moved_reg <= {NUM_SLOTS{1'b0}};
            order_len <= {(IDX_W+1){1'b0}};
            remap_cnt_reg <= 2'h0;
            build_r_reg <= {(IDX_W+1){1'b0}};
            state_reg <= ctrl_reg[`SHR_CTRL_SYNC_EN] ? S_SYNC : S_TRK;
          end
        end
        S_SYNC: if (cw_take) begin
          err_pulse_reg[`SHR_ERR_SYNC] <= cw_data != 16'h0000;
          state_reg <= S_TRK;
        end
        S_TRK: if (cw_take) begin
          err_pulse_reg[`SHR_ERR_TR_KIND] <= cw_data != 16'h0000;
          state_reg <= S_TRV;
        end
        S_TRV: if (cw_take) begin
          temporal_ref_value <= cw_data[`SHR_PN_W-1:0];
          state_reg <= S_KIND;
        end
        S_KIND: if (cw_take) begin
          picture_kind <= cw_data[2:0];
          per_mb_ref_select <= cw_data == 16'h0001 || cw_data == 16'h0004 ||
                               cw_data == 16'h0006;
          err_pulse_reg[`SHR_ERR_KIND] <= cw_data > `SHR_KIND_MAX;
          state_reg <= S_LAYOUT;
        end
        S_LAYOUT: if (cw_take) begin
          picture_layout <= cw_data[2:0];
          err_pulse_reg[`SHR_ERR_LAYOUT] <= cw_data > `SHR_LAYOUT_MAX;
          state_reg <= S_SIZEF;
        end
        S_SIZEF: if (cw_take) begin
          state_reg <= (cw_data != 16'h0000) ? S_WID : S_FMB;
        end
        S_WID: if (cw_take) begin
          width_reg <= cw_data;
          state_reg <= S_HGT;
        end
        S_HGT: if (cw_take) begin
          height_reg <= cw_data;
          state_reg <= S_FMB;
        end
        S_FMB: if (cw_take) begin
          first_mb_reg <= cw_data;
          state_reg <= S_SQP;
        end
        S_SQP: if (cw_take) begin
          slice_quantiser <= cw_data[5:0];
          quantiser_param <= $signed({1'b0, cw_data[5:0]}) - $signed(`SHR_QP_OFFSET);
          state_reg <= kind_switching ? S_SPQP : (arith_entropy_coding ? S_MBC : S_PN);
        end
        S_SPQP: if (cw_take) begin
          sp_quantiser <= cw_data[5:0];
          state_reg <= arith_entropy_coding ? S_MBC : S_PN;
        end
        S_MBC: if (cw_take) begin
          mb_count_reg <= cw_data;
          state_reg <= S_PN;
        end
        S_PN: if (cw_take) begin
          picture_number <= cw_data[`SHR_PN_W-1:0];
          pred_reg <= cw_data[`SHR_PN_W-1:0];
          err_pulse_reg[`SHR_ERR_PN_DUP] <= pn_dup;
          state_reg <= S_REF_SELECT_LAYER_FLAG;
        end
        S_REF_SELECT_LAYER_FLAG: if (cw_take) begin
          if (cw_data == 16'h0000) begin
            state_reg <= S_BUILD;
          end else begin
            state_reg <= kind_intra ? S_REF_BUFFERING_KIND : S_OP;
          end
        end
        S_OP: if (cw_take) begin
          if (cw_data == `SHR_OP_END) begin
            state_reg <= kind_pred ? S_REF_BUFFERING_KIND : S_BUILD;
          end else if (cw_data > `SHR_OP_END) begin
            err_pulse_reg[`SHR_ERR_OP] <= 1'b1;
            state_reg <= S_BUILD;
          end else begin
            remap_op_code <= cw_data[1:0];
            state_reg <= S_ARG;
          end
        end
        S_ARG: if (cw_take) begin
          if (remap_cnt_reg >= remap_limit) begin
            err_pulse_reg[`SHR_ERR_LIMIT] <= 1'b1;
          end else begin
            remap_cnt_reg <= remap_cnt_reg + 2'h1;
            if (hit) begin
              order_slots[order_len[IDX_W-1:0]*IDX_W +: IDX_W] <= hit_idx;
              order_len <= order_len + 1'b1;
              moved_reg[hit_idx] <= 1'b1;
            end else begin
              err_pulse_reg[`SHR_ERR_NOT_FOUND] <= 1'b1;
            end
          end
          if (remap_op_code != `SHR_OP_LONG) begin
            pred_reg <= target_num;
          end
          state_reg <= S_OP;
        end
        S_REF_BUFFERING_KIND: if (cw_take) begin
          ref_buffering_kind <= cw_data[1:0];
          state_reg <= S_BUILD;
        end
        S_BUILD: begin
          // unmoved pictures follow in default order
          if (bhit && !moved_reg[bidx] && order_len < NUM_SLOTS) begin
            order_slots[order_len[IDX_W-1:0]*IDX_W +: IDX_W] <= bidx;
            order_len <= order_len + 1'b1;
          end
          build_r_reg <= build_r_reg + 1'b1;
          if (build_r_reg == NUM_SLOTS - 1) begin
            order_done <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ******************************
  // register slave
  // ******************************
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = !s_axi_rvalid;
  wire wr_ctrl = wr_go && s_axi_awaddr == `SHR_REG_CTRL;
  wire wr_status = wr_go && s_axi_awaddr == `SHR_REG_STATUS;
  wire [`SHR_ERR_W-1:0] err_clr = (wr_status && s_axi_wstrb[1]) ?
                                  s_axi_wdata[8 +: `SHR_ERR_W] : {`SHR_ERR_W{1'b0}};
  integer b;

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= `SHR_CTRL_RESET;
      err_reg <= {`SHR_ERR_W{1'b0}};
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      // a new error wins over a clear in the same cycle
      err_reg <= (err_reg & ~err_clr) | err_pulse_reg;
      if (wr_ctrl) begin
        for (b = 0; b < 4; b = b + 1) begin
          if (s_axi_wstrb[b]) begin
            ctrl_reg[b*8 +: 8] <= s_axi_wdata[b*8 +: 8];
          end
        end
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_ctrl || wr_status) ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          `SHR_REG_CTRL: s_axi_rdata <= ctrl_reg;
          `SHR_REG_STATUS: s_axi_rdata <= {16'h0000, err_reg, 7'h00, slice_busy};
          `SHR_REG_PIC: s_axi_rdata <= {8'h00, 6'h00, ref_buffering_kind, 5'h00,
                                        picture_layout, 5'h00, picture_kind};
          `SHR_REG_PICNUM: s_axi_rdata <= {6'h00, temporal_ref_value, 6'h00, picture_number};
          `SHR_REG_QUANT: s_axi_rdata <= {18'h00000, sp_quantiser, 2'h0, slice_quantiser};
          `SHR_REG_SIZE: s_axi_rdata <= {height_reg, width_reg};
          `SHR_REG_MB: s_axi_rdata <= {mb_count_reg, first_mb_reg};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== src/shr_defines.vh ====
`ifndef SHR_DEFINES_VH
`define SHR_DEFINES_VH
`define SHR_CW_W 16
`define SHR_PN_W 10
`define SHR_REG_CTRL 8'h00
`define SHR_REG_STATUS 8'h04
`define SHR_REG_PIC 8'h08
`define SHR_REG_PICNUM 8'h0C
`define SHR_REG_QUANT 8'h10
`define SHR_REG_SIZE 8'h14
`define SHR_REG_MB 8'h18
`define SHR_CTRL_SYNC_EN 0
`define SHR_CTRL_ARITH 1
`define SHR_CTRL_MLT_LSB 8
`define SHR_CTRL_RESET 32'h0000_0000
`define SHR_ERR_SYNC 0
`define SHR_ERR_TR_KIND 1
`define SHR_ERR_KIND 2
`define SHR_ERR_LAYOUT 3
`define SHR_ERR_PN_DUP 4
`define SHR_ERR_OP 5
`define SHR_ERR_LIMIT 6
`define SHR_ERR_NOT_FOUND 7
`define SHR_ERR_W 8
`define SHR_KIND_MAX 16'h0007
`define SHR_LAYOUT_MAX 16'h0004
`define SHR_OP_NEG 2'h0
`define SHR_OP_POS 2'h1
`define SHR_OP_LONG 2'h2
`define SHR_OP_END 16'h0003
`define SHR_QP_OFFSET 7'h0C
`define SHR_REMAP_LIMIT_ONE 2'h1
`define SHR_REMAP_LIMIT_BI 2'h2
`endif

// ==== src/shr_rank_cell.v ====
`timescale 1ns/1ps
`default_nettype none
`include "shr_defines.vh"
module shr_rank_cell #(
  parameter NUM_SLOTS = 16,
  parameter IDX_W = 4,
  parameter SELF = 0
) (
  input wire [NUM_SLOTS-1:0] slot_valid, // slot holds a reference picture
  input wire [NUM_SLOTS-1:0] slot_long, // slot is long-term
  input wire [NUM_SLOTS*`SHR_PN_W-1:0] slot_num, // picture number or long index
  input wire [`SHR_PN_W-1:0] cur_num, // current picture number
  input wire [`SHR_PN_W-1:0] lt_limit, // long-term index bound
  output reg in_order, // slot takes part in default order
  output reg [IDX_W:0] rank // default relative index of this slot
);
  integer j;
  reg [`SHR_PN_W-1:0] own_num;
  reg [`SHR_PN_W-1:0] num_j;
  reg [`SHR_PN_W-1:0] age_self;
  reg [`SHR_PN_W-1:0] age_j;
  reg [IDX_W:0] short_cnt;
  reg [IDX_W:0] before_cnt;
  always @* begin
    own_num = slot_num[SELF*`SHR_PN_W +: `SHR_PN_W];
    age_self = cur_num - own_num;
    short_cnt = {(IDX_W+1){1'b0}};
    before_cnt = {(IDX_W+1){1'b0}};
    num_j = {`SHR_PN_W{1'b0}};
    age_j = {`SHR_PN_W{1'b0}};
    for (j = 0; j < NUM_SLOTS; j = j + 1) begin
      num_j = slot_num[j*`SHR_PN_W +: `SHR_PN_W];
      age_j = cur_num - num_j;
      if (slot_valid[j] && !slot_long[j]) begin
        short_cnt = short_cnt + 1'b1;
        // modular age keeps newest-first correct across the wrap
        if (!slot_long[SELF] && (age_j < age_self || (age_j == age_self && j < SELF))) begin
          before_cnt = before_cnt + 1'b1;
        end
      end
      if (slot_valid[j] && slot_long[j] && slot_long[SELF] && num_j < lt_limit &&
          (num_j < own_num || (num_j == own_num && j < SELF))) begin
        before_cnt = before_cnt + 1'b1;
      end
    end
    in_order = slot_valid[SELF] && (!slot_long[SELF] || own_num < lt_limit);
    rank = slot_long[SELF] ? short_cnt + before_cnt : before_cnt;
  end
endmodule
`default_nettype wire

// ==== tb/shr_checker_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// port checker for the slice header parser
// ************************************************************
module shr_checker #(
  parameter NUM_SLOTS = 16,
  parameter IDX_W = 4
) (
  input wire logic core_clk, // clock
  input wire logic reset_n, // reset, active low
  input wire logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  input wire logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data ready
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic s_axi_rvalid, // read data valid
  input wire logic slice_start, // slice start pulse
  input wire logic cw_ready, // code number ready
  input wire logic slice_busy, // header being parsed
  input wire logic order_done, // order complete pulse
  input wire logic [NUM_SLOTS*IDX_W-1:0] order_slots, // slot per index
  input wire logic [IDX_W:0] order_len, // entries in order
  input wire logic per_mb_ref_select, // per macroblock choice
  input wire logic [2:0] picture_kind, // picture kind
  input wire logic signed [6:0] quantiser_param // slice quantiser
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  chk_aw_pair: assert property (s_axi_awready |-> s_axi_awvalid && s_axi_wvalid && s_axi_wready)
    else $error("write channels not taken together");
  chk_b_follow: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write response missing");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_r_follow: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  chk_start_busy: assert property (slice_start && !slice_busy |=> slice_busy)
    else $error("slice start ignored");
  chk_ready_busy: assert property (cw_ready |-> slice_busy)
    else $error("code taken while idle");
  chk_done_end: assert property (
    order_done |-> !slice_busy ##1 !order_done)
    else $error("done pulse wrong");
  chk_order_hold: assert property (
    !slice_busy && !$past(slice_busy) |-> $stable(order_slots) && $stable(order_len))
    else $error("order changed while idle");
  chk_mb_select: assert property (
    !slice_busy |-> per_mb_ref_select == (picture_kind inside {3'h1, 3'h4, 3'h6}))
    else $error("macroblock selection flag wrong");
  chk_qp_range: assert property (
    !slice_busy |-> quantiser_param >= -7'sd12 && quantiser_param <= 7'sd39)
    else $error("quantiser out of range");
  chk_len_bound: assert property (
    order_len <= NUM_SLOTS)
    else $error("order too long");
endmodule

bind shr_ref_order shr_checker #(.NUM_SLOTS(NUM_SLOTS), .IDX_W(IDX_W)) chk_u (
  .core_clk(core_clk), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .slice_start(slice_start),
  .cw_ready(cw_ready), .slice_busy(slice_busy), .order_done(order_done),
  .order_slots(order_slots), .order_len(order_len), .per_mb_ref_select(per_mb_ref_select),
  .picture_kind(picture_kind), .quantiser_param(quantiser_param));
`default_nettype wire

// ==== tb/shr_enc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "shr_defines.vh"
// ************************************************************
// encoder side: offers queued code numbers on the handshake
// ************************************************************
module shr_enc_model (
  input wire logic core_clk, // clock
  input wire logic slow, // insert gaps between codes
  input wire logic cw_ready, // code taken when high with valid
  output logic cw_valid, // code offered
  output logic [`SHR_CW_W-1:0] cw_data // code number
);
  logic [`SHR_CW_W-1:0] q[$];
  logic [`SHR_CW_W-1:0] last = 16'h0000;
  int gap = 0;
  initial begin
    cw_valid = 1'b0;
    cw_data = 16'hFFFF;
  end
  task automatic send(input int v);
    q.push_back(v[`SHR_CW_W-1:0]);
  endtask
  // offered code holds until taken; idle data shows inverse of last code
  always @(posedge core_clk) begin
    if (cw_valid && cw_ready) begin
      last = q.pop_front();
      gap = slow ? 2 : 0;
    end
    if (gap > 0 || q.size() == 0) begin
      if (gap > 0) gap--;
      cw_valid <= 1'b0;
      cw_data <= ~last;
    end else begin
      cw_valid <= 1'b1;
      cw_data <= q[0];
    end
  end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "shr_defines.vh"
module testbench;
  logic core_clk = 1'b0, reset_n = 1'b0, slice_start = 1'b0, slow = 1'b0, cfg = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [15:0] slot_valid = 16'h0, slot_long = 16'h0;
  logic [159:0] slot_num = 160'h0;
  logic [`SHR_CW_W-1:0] cw_data;
  logic cw_valid;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cw_ready;
  wire [1:0] s_axi_bresp, s_axi_rresp, ref_buffering_kind;
  wire [31:0] s_axi_rdata;
  wire [63:0] order_slots;
  wire [4:0] order_len;
  wire order_done, slice_busy, per_mb_ref_select;
  wire [2:0] picture_kind, picture_layout;
  wire signed [6:0] quantiser_param;
  int errors = 0, tests_run = 0;

  shr_ref_order dut_u (.core_clk(core_clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .slice_start(slice_start), .cw_data(cw_data),
    .cw_valid(cw_valid), .cw_ready(cw_ready), .slot_valid(slot_valid), .slot_long(slot_long),
    .slot_num(slot_num), .order_slots(order_slots), .order_len(order_len),
    .order_done(order_done), .slice_busy(slice_busy), .per_mb_ref_select(per_mb_ref_select),
    .picture_kind(picture_kind), .picture_layout(picture_layout),
    .quantiser_param(quantiser_param), .ref_buffering_kind(ref_buffering_kind));
  shr_enc_model enc_u (.core_clk(core_clk), .slow(slow), .cw_ready(cw_ready),
    .cw_valid(cw_valid), .cw_data(cw_data));

  initial forever #50 core_clk = ~core_clk;

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] v);
    tests_run++;
    if (v !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge core_clk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (s_axi_bvalid !== 1'b1) @(posedge core_clk);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge core_clk);
    s_axi_rready <= 1'b0;
    chk("rdata", ed, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask
  task automatic hdr(input int k, input int lay, input int pn, input int bad, input bit sz);
    if (cfg) enc_u.send(bad);
    enc_u.send(bad);
    enc_u.send(7);
    enc_u.send(k);
    enc_u.send(lay);
    enc_u.send(sz);
    if (sz) begin
      enc_u.send(22);
      enc_u.send(18);
    end
    enc_u.send(2);
    enc_u.send(k + 20);
    if (k >= 5) enc_u.send(30);
    if (cfg) enc_u.send(9);
    enc_u.send(pn);
  endtask
  task automatic run_slice;
    int n;
    @(posedge core_clk);
    slice_start <= 1'b1;
    @(posedge core_clk);
    slice_start <= 1'b0;
    n = 0;
    while (order_done !== 1'b1 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    chk("order_done", 1, order_done);
  endtask
  task automatic ord(input int e[$]);
    chk("order_len", e.size(), order_len);
    foreach (e[i]) chk("order_slot", e[i], order_slots[i*4+:4]);
  endtask
  task automatic sl(input int k, input int ops[$], input int e[$]);
    hdr(k, 0, 'h130, 0, 1'b0);
    enc_u.send(1);
    foreach (ops[i]) enc_u.send(ops[i]);
    run_slice;
    ord(e);
  endtask
  task automatic close_out;
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #2000000;
    errors++;
    close_out;
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    slot_valid <= 16'h001F;
    slot_long <= 16'h0018;
    slot_num <= 160'({10'h003, 10'h000, 10'h12F, 10'h12E, 10'h12C});
    axr(`SHR_REG_CTRL, 32'h0, 2'h0);
    axr(`SHR_REG_STATUS, 32'h0, 2'h0);
    axr(8'h1C, 32'h0, 2'h2);
    axw(`SHR_REG_PIC, 32'h0, 4'hF, 2'h2);
    hdr(2, 1, 'h130, 0, 1'b0);
    enc_u.send(0);
    run_slice;
    ord('{2, 1, 0});
    axr(`SHR_REG_MB, 32'h0000_0002, 2'h0);
    axw(`SHR_REG_CTRL, 32'h403, 4'hF, 2'h0);
    axr(`SHR_REG_CTRL, 32'h403, 2'h0);
    cfg = 1'b1;
    for (int k = 0; k < 8; k++) begin
      slow <= k[0];
      hdr(k, k % 5, 'h130, 0, k == 3);
      enc_u.send(0);
      run_slice;
      chk("kind", k, picture_kind);
      chk("layout", k % 5, picture_layout);
      chk("mb_select", k == 1 || k == 4 || k == 6, per_mb_ref_select);
      chk("quant", k + 8, quantiser_param);
      ord('{2, 1, 0, 3, 4});
      if (k == 6) axr(`SHR_REG_QUANT, 32'h1E1A, 2'h0);
      if (k == 6) axr(`SHR_REG_MB, 32'h0009_0002, 2'h0);
      if (k == 3) axr(`SHR_REG_SIZE, 32'h0012_0016, 2'h0);
      if (k == 0) axr(`SHR_REG_PICNUM, 32'h0007_0130, 2'h0);
      if (k == 4) axr(`SHR_REG_PIC, 32'h0000_0404, 2'h0);
    end
    sl(1, '{0, 1, 3, 1}, '{1, 2, 0, 3, 4});
    chk("buffering", 1, ref_buffering_kind);
    sl(3, '{2, 3, 0, 0, 3}, '{4, 2, 1, 0, 3});
    sl(4, '{0, 1, 1, 0, 3}, '{1, 2, 0, 3, 4});
    sl(0, '{2, 0, 2, 3, 3, 0}, '{3, 2, 1, 0, 4});
    axr(`SHR_REG_STATUS, 32'h4000, 2'h0);
    slot_num <= 160'({10'h003, 10'h000, 10'h000, 10'h3FF, 10'h3FE});
    slot_valid <= 16'h0017;
    slot_long <= 16'h0019;
    hdr(0, 0, 1, 0, 1'b0);
    enc_u.send(0);
    run_slice;
    ord('{2, 1, 4});
    hdr(0, 5, 'h3FF, 1, 1'b0);
    enc_u.send(1);
    enc_u.send(5);
    run_slice;
    axr(`SHR_REG_STATUS, 32'h7B00, 2'h0);
    axw(`SHR_REG_STATUS, 32'hFF00, 4'h2, 2'h0);
    axr(`SHR_REG_STATUS, 32'h0, 2'h0);
    close_out;
  end
endmodule
`default_nettype wire
